// *** e1_alarm_hdlc_irq_status.sv ***
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module e1_alarm_hdlc_irq_status (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Framer alarm levels
  input  wire logic        rx_signal_loss,
  input  wire logic        crc_mf_locked,
  input  wire logic        cas_mf_locked,
  input  wire logic        ts16_all_ones_alarm,
  // Second HDLC controller events
  input  wire logic        tx_msg_begin,
  input  wire logic        rx_msg_begin,
  input  wire logic        tx_msg_done,
  input  wire logic        rx_msg_kind_valid,
  input  wire logic        rx_msg_kind,
  // Interrupt
  output logic             irq
);
  import irq_pkg::*;

  // ==========================================================================
  // State
  localparam int LINK_EVENTS = LINK_EV_HI - LINK_EV_LO + 1;
  logic [3:0]  alarm_lvl_r;
  logic [3:0]  alarm_flag;
  logic [2:0]  link_flag;
  logic [3:0]  alarm_irq_enable_r;
  logic [2:0]  link_en_r;
  logic        link_message_kind_r;
  logic        aw_held_r;
  logic [7:0]  aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic        w_lane0_r;
  logic        rd_busy_r;
  logic        irq_r;

  // ==========================================================================
  // Alarm change detection: any toggle of a framer level is an event
  wire  [3:0]  alarm_lvl_now = {rx_signal_loss, crc_mf_locked, cas_mf_locked,
                                ts16_all_ones_alarm};
  wire  [3:0]  alarm_ev;
  assign alarm_ev[BIT_TS16]   = alarm_lvl_now[BIT_TS16] ^ alarm_lvl_r[BIT_TS16];
  assign alarm_ev[BIT_CAS_MF] = alarm_lvl_now[BIT_CAS_MF] ^ alarm_lvl_r[BIT_CAS_MF];
  assign alarm_ev[BIT_CRC_MF] = alarm_lvl_now[BIT_CRC_MF] ^ alarm_lvl_r[BIT_CRC_MF];
  assign alarm_ev[BIT_RX_LOS] = alarm_lvl_now[BIT_RX_LOS] ^ alarm_lvl_r[BIT_RX_LOS];

  // Link events in status order bit 4..6
  wire  [2:0]  link_ev = {tx_msg_begin,
                          rx_msg_begin,
                          tx_msg_done};

  // ==========================================================================
  // Address decode, one select per register on the read side
  wire         ra_alarm_st  = (s_axi_araddr == OFS_ALARM_STATUS);
  wire         ra_alarm_en  = (s_axi_araddr == OFS_ALARM_ENABLE);
  wire         ra_link_st   = (s_axi_araddr == OFS_LINK_STATUS);
  wire         ra_link_en   = (s_axi_araddr == OFS_LINK_ENABLE);
  wire         ra_link_clr  = (s_axi_araddr == OFS_LINK_CLEAR);
  wire         ra_alarm_clr = (s_axi_araddr == OFS_ALARM_CLEAR);
  wire         ra_alarm_lvl = (s_axi_araddr == OFS_ALARM_STATE);

  // Write selects look at the held address
  wire         wa_alarm_st  = (aw_addr_r == OFS_ALARM_STATUS);
  wire         wa_alarm_en  = (aw_addr_r == OFS_ALARM_ENABLE);
  wire         wa_link_st   = (aw_addr_r == OFS_LINK_STATUS);
  wire         wa_link_en   = (aw_addr_r == OFS_LINK_ENABLE);
  wire         wa_link_clr  = (aw_addr_r == OFS_LINK_CLEAR);
  wire         wa_alarm_clr = (aw_addr_r == OFS_ALARM_CLEAR);
  wire         wa_alarm_lvl = (aw_addr_r == OFS_ALARM_STATE);

  // ==========================================================================
  // Bus decode
  wire         wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;
  wire         rd_fire   = s_axi_arvalid && s_axi_arready;
  wire         rd_alarm  = rd_fire && ra_alarm_st;
  wire         rd_link   = rd_fire && ra_link_st;
  wire         wr_hit    = wr_fire && w_lane0_r;
  wire         wr_a_en   = wr_hit && wa_alarm_en;
  wire         wr_l_en   = wr_hit && wa_link_en;
  wire         wr_a_clr  = wr_hit && wa_alarm_clr;
  wire         wr_l_clr  = wr_hit && wa_link_clr;
  // Status and level registers ignore a write but answer OKAY
  wire         wr_known  = wa_alarm_st || wa_alarm_en || wa_link_st || wa_link_en
                        || wa_link_clr || wa_alarm_clr || wa_alarm_lvl;
  // Clear registers read back as zero
  wire         rd_known  = ra_alarm_st || ra_alarm_en || ra_link_st || ra_link_en
                        || ra_link_clr || ra_alarm_clr || ra_alarm_lvl;

  // Clear by read of status or by write-one to clear register
  wire  [3:0]  alarm_clr = ({4{rd_alarm}}
                          | ({4{wr_a_clr}} & w_data_r[3:0]));
  wire  [2:0]  link_clr  = ({3{rd_link}}
                          | ({3{wr_l_clr}} & w_data_r[LINK_EV_HI:LINK_EV_LO]));

  // ==========================================================================
  // Sticky flags, set wins over clear
  edge_flag #(.N(ALARM_EVENTS)) u_alarm_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_ev  (alarm_ev),
    .clr     (alarm_clr),
    .flag    (alarm_flag)
  );

  edge_flag #(.N(LINK_EVENTS)) u_link_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set_ev  (link_ev),
    .clr     (link_clr),
    .flag    (link_flag)
  );

  // ==========================================================================
  // Read data mux
  wire  [7:0]  alarm_status_byte = {3'h0, alarm_lvl_r[BIT_TS16], alarm_flag};
  wire  [7:0]  link_status_byte  = {link_message_kind_r, link_flag, 4'h0};
  wire  [7:0]  alarm_state_byte  = {4'h0, alarm_lvl_r};
  wire  [7:0]  alarm_enable_byte = {4'h0, alarm_irq_enable_r};
  wire  [7:0]  link_enable_byte  = {1'b0, link_en_r, 4'h0};
  wire  [7:0]  rd_byte =
      ra_alarm_st  ? alarm_status_byte :
      ra_alarm_en  ? alarm_enable_byte :
      ra_link_st   ? link_status_byte :
      ra_link_en   ? link_enable_byte :
      ra_alarm_lvl ? alarm_state_byte : RST_BYTE;

  // ==========================================================================
  // Interrupt: alarm enables are active low, link enables active high
  wire         irq_nxt = |(alarm_flag & ~alarm_irq_enable_r)
                       | |(link_flag & link_en_r);

  // Framer level history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alarm_lvl_r <= RST_NIBBLE;
    else
      alarm_lvl_r <= alarm_lvl_now;
  end

  // Message kind of last received message
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      link_message_kind_r <= 1'b0;
    else if (rx_msg_kind_valid)
      link_message_kind_r <= rx_msg_kind;
  end

  // Enable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_irq_enable_r <= RST_NIBBLE;
      link_en_r          <= RST_LINK_EN;
    end
    else
    begin
      if (wr_a_en)
        alarm_irq_enable_r <= w_data_r[3:0];
      if (wr_l_en)
        link_en_r <= w_data_r[LINK_EV_HI:LINK_EV_LO];
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= RST_BYTE;
      w_data_r  <= ZERO_WORD;
      w_lane0_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_lane0_r <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  // Address and data channels reopen only once the response is taken
  wire         aw_open = !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
  wire         w_open  = !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;

  // Write handshake and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= aw_open;
      s_axi_wready  <= w_open;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read handshake and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO_WORD;
      s_axi_rresp   <= RESP_OKAY;
      rd_busy_r     <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !rd_busy_r && !rd_fire;
      if (rd_fire)
      begin
        rd_busy_r    <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        rd_busy_r    <= 1'b0;
      end
    end
  end

  // Registered interrupt output
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_r <= 1'b0;
    else
      irq_r <= irq_nxt;
  end

  assign irq = irq_r;

endmodule : e1_alarm_hdlc_irq_status

`default_nettype wire

// *** irq_pkg.sv ***
package irq_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_ALARM_STATUS = 8'h00;
  localparam logic [7:0] OFS_ALARM_ENABLE = 8'h04;
  localparam logic [7:0] OFS_LINK_STATUS  = 8'h08;
  localparam logic [7:0] OFS_LINK_ENABLE  = 8'h0c;
  localparam logic [7:0] OFS_LINK_CLEAR   = 8'h10;
  localparam logic [7:0] OFS_ALARM_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_ALARM_STATE  = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int BIT_TS16      = 0;
  localparam int BIT_CAS_MF    = 1;
  localparam int BIT_CRC_MF    = 2;
  localparam int BIT_RX_LOS    = 3;
  localparam int BIT_TS16_LVL  = 4;
  localparam int BIT_TX_DONE   = 4;
  localparam int BIT_RX_BEGIN  = 5;
  localparam int BIT_TX_BEGIN  = 6;
  localparam int BIT_MSG_KIND  = 7;
  localparam int ALARM_EVENTS  = 4;
  localparam int LINK_EV_LO    = 4;
  localparam int LINK_EV_HI    = 6;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [3:0]  RST_NIBBLE  = 4'h0;
  localparam logic [2:0]  RST_LINK_EN = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

endpackage : irq_pkg

// *** edge_flag.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Per-bit sticky event flags with set-over-clear
module edge_flag #(
  parameter int N = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] set_ev,
  input  wire logic [N-1:0] clr,
  output logic      [N-1:0] flag
);
  import irq_pkg::*;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      // Event in the clearing cycle keeps the flag set
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          flag[i] <= 1'b0;
        else if (set_ev[i])
          flag[i] <= 1'b1;
        else if (clr[i])
          flag[i] <= 1'b0;
      end
    end
  endgenerate

endmodule : edge_flag

`default_nettype wire

// *** irq_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Bus and interrupt checker
module irq_monitor
  import irq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        ts16_all_ones_alarm,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read acceptance; any address off the register map is refused
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_map  = (s_axi_araddr == OFS_ALARM_STATUS) || (s_axi_araddr == OFS_ALARM_ENABLE)
              || (s_axi_araddr == OFS_LINK_STATUS) || (s_axi_araddr == OFS_LINK_ENABLE)
              || (s_axi_araddr == OFS_LINK_CLEAR) || (s_axi_araddr == OFS_ALARM_CLEAR)
              || (s_axi_araddr == OFS_ALARM_STATE);
  wire rd_bad  = rd_take && !rd_map;

  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_unmapped_err: assert property (rd_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == ZERO_WORD)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (rd_take && !rd_bad |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_level_read: assert property (rd_take && s_axi_araddr == OFS_ALARM_STATE
      && $stable(ts16_all_ones_alarm) |=> s_axi_rdata[0] == $past(ts16_all_ones_alarm))
    else $error("alarm level misread");
  chk_reset_quiet: assert property (!$past(aresetn) |-> !irq && !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs busy after reset");

  cov_read: cover property (rd_take);
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_irq: cover property ($rose(irq));
endmodule : irq_monitor

bind e1_alarm_hdlc_irq_status irq_monitor irq_monitor_i (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .ts16_all_ones_alarm, .irq);

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb_top;
  import irq_pkg::*;
  logic        aclk, aresetn, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, lvl;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        kind_vld, kind;
  logic [6:4]  ev;
  int          failures, samples_checked;

  e1_alarm_hdlc_irq_status e1_alarm_hdlc_irq_status_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_signal_loss(lvl[3]), .crc_mf_locked(lvl[2]), .cas_mf_locked(lvl[1]),
    .ts16_all_ones_alarm(lvl[0]), .tx_msg_begin(ev[6]), .rx_msg_begin(ev[5]),
    .tx_msg_done(ev[4]), .rx_msg_kind_valid(kind_vld), .rx_msg_kind(kind), .irq);

  // ==========================================================================
  // Clock and helpers
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic close_out;
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic guard(input int k);
    if (k >= 50)
    begin
      failures++;
      close_out();
    end
  endtask : guard

  // Write: offer address and data, drop each when taken, wait for the answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] r = RESP_OKAY);
    int k;
    k = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 1'b0;
    guard(k);
    `CHK("bresp", r, s_axi_bresp)
  endtask : axi_write

  // Read: hold the request until taken, compare the answer
  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int k;
    k = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && k < 50);
    s_axi_rready <= 1'b0;
    guard(k);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask : axi_read

  // ==========================================================================
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, lvl, ev, kind_vld, kind} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    failures = 0;
    samples_checked = 0;
    tick(20);
    aresetn <= 1'b1;
    tick(2);
    axi_read(OFS_ALARM_ENABLE, 32'h0, RESP_OKAY);
    axi_read(OFS_ALARM_STATUS, 32'h0, RESP_OKAY);
    axi_read(OFS_LINK_STATUS, 32'h0, RESP_OKAY);
    // Each alarm: rise, read twice, fall, clearing write
    for (int i = 0; i < 4; i++)
    begin
      lvl[i] <= 1'b1;
      tick(3);
      `CHK("irq", 1'b1, irq)
      axi_read(OFS_ALARM_STATUS, (32'h1 << i) | {lvl[0], 4'h0}, RESP_OKAY);
      axi_read(OFS_ALARM_STATUS, {lvl[0], 4'h0}, RESP_OKAY);
      `CHK("irq", 1'b0, irq)
      lvl[i] <= 1'b0;
      tick(3);
      `CHK("irq", 1'b1, irq)
      axi_write(OFS_ALARM_CLEAR, 32'h1 << i);
      axi_read(OFS_ALARM_STATUS, 32'h0, RESP_OKAY);
    end
    // Disabled alarm still records its event
    axi_write(OFS_ALARM_ENABLE, 32'h0f);
    axi_read(OFS_ALARM_ENABLE, 32'h0f, RESP_OKAY);
    lvl[1] <= 1'b1;
    tick(3);
    `CHK("irq", 1'b0, irq)
    axi_read(OFS_ALARM_STATUS, 32'h2, RESP_OKAY);
    axi_read(OFS_ALARM_STATE, 32'h2, RESP_OKAY);
    // Only the CAS change enabled: its change raises the line again
    axi_write(OFS_ALARM_ENABLE, 32'h0d);
    lvl[1] <= 1'b0;
    tick(3);
    `CHK("irq", 1'b1, irq)
    axi_read(OFS_ALARM_STATUS, 32'h2, RESP_OKAY);
    // Link event with its enable off is recorded but stays quiet
    ev[5] <= 1'b1;
    tick(1);
    ev[5] <= 1'b0;
    tick(3);
    `CHK("irq", 1'b0, irq)
    axi_read(OFS_LINK_STATUS, 32'h20, RESP_OKAY);
    // Link events
    axi_write(OFS_LINK_ENABLE, 32'h70);
    axi_read(OFS_LINK_ENABLE, 32'h70, RESP_OKAY);
    // Write without the low byte lane leaves the register alone
    s_axi_wstrb <= 4'he;
    axi_write(OFS_LINK_ENABLE, 32'h0);
    s_axi_wstrb <= 4'hf;
    axi_read(OFS_LINK_ENABLE, 32'h70, RESP_OKAY);
    axi_write(8'h40, 32'h0, RESP_SLVERR);
    for (int b = 4; b < 7; b++)
    begin
      ev[b] <= 1'b1;
      tick(1);
      ev[b] <= 1'b0;
      tick(3);
      `CHK("irq", 1'b1, irq)
      axi_read(OFS_LINK_STATUS, 32'h1 << b, RESP_OKAY);
    end
    ev[6] <= 1'b1;
    tick(1);
    ev[6] <= 1'b0;
    axi_write(OFS_LINK_CLEAR, 32'h40);
    axi_read(OFS_LINK_STATUS, 32'h0, RESP_OKAY);
    // Host work done, then the transmit end event
    ev[4] <= 1'b1;
    tick(1);
    ev[4] <= 1'b0;
    tick(3);
    `CHK("irq", 1'b1, irq)
    axi_read(OFS_LINK_STATUS, 32'h10, RESP_OKAY);
    // Event at the acceptance edge of a clearing read survives
    tick(2);
    ev[6] <= 1'b1;
    fork
      axi_read(OFS_LINK_STATUS, 32'h0, RESP_OKAY);
      begin
        tick(1);
        ev[6] <= 1'b0;
      end
    join
    axi_read(OFS_LINK_STATUS, 32'h40, RESP_OKAY);
    // Message kind latch, both values
    kind_vld <= 1'b1;
    kind <= 1'b1;
    tick(1);
    {kind_vld, kind} <= 2'b00;
    tick(2);
    axi_read(OFS_LINK_STATUS, 32'h80, RESP_OKAY);
    axi_read(OFS_LINK_STATUS, 32'h80, RESP_OKAY);
    kind_vld <= 1'b1;
    tick(1);
    kind_vld <= 1'b0;
    tick(2);
    axi_read(OFS_LINK_STATUS, 32'h0, RESP_OKAY);
    axi_read(8'h40, 32'h0, RESP_SLVERR);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
